// [rtl/ddr_cmd_logic.sv]
// Command decoder, bank state and power-state tracking of a DDR memory.
// Assumes all pins are asynchronous to clk; each is synchronised before use,
// and the memory clock is sampled and its rising edges found in clk.
//
// How it works
// - Burst stop hits only the reading bank
// - Clock enable low twice holds; rise exits
// - Falling enable picks precharge or active power-down
// - Refresh with enable falling enters self refresh
// - Self refresh exit waits for lock
// - Chip select high registers nothing
// - No-operation registers nothing new
// - Activate opens row in selected bank
// - Read takes column from low address
// - Write takes column from low address
// - Precharge closes one or all banks
// - Burst stop truncates latest non-AP read
// - Bank idle only after precharge period
// - Commands decode from four strobes
`timescale 1ns/10ps
module ddr_cmd_logic
    import ddr_cmd_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Memory-side pins
    input  wire logic                   mem_clk,
    input  wire logic                   cke,
    input  wire logic                   cs_n,
    input  wire logic                   ras_n,
    input  wire logic                   cas_n,
    input  wire logic                   we_n,
    input  wire logic [ddr_cmd_pkg::BANK_W-1:0] bank_sel,
    input  wire logic [ddr_cmd_pkg::ADDR_W-1:0] addr,
    // Event stream out
    output logic                        ev_valid,
    input  wire logic                   ev_ready,
    output logic [WIDTH-1:0]            ev_data,
    // State
    output logic [ddr_cmd_pkg::NUM_BANKS-1:0] bank_open_q,
    output logic [ddr_cmd_pkg::NUM_BANKS-1:0] bank_idle_q,
    output logic [3:0]                  power_state_q,
    output logic                        read_ready_q,
    output logic                        cmd_lost_q
);
    import ddr_cmd_pkg::*;

    logic [1:0] clk_s_q, cke_s_q, cs_s_q, ras_s_q, cas_s_q, we_s_q;
    logic [BANK_W-1:0] ba_s1_q, ba_s2_q;
    logic [ADDR_W-1:0] a_s1_q, a_s2_q;
    logic clk_prev_q;
    logic cke_prev_q;
    logic [ADDR_W-1:0] mode_q;
    logic [BANK_W-1:0] rd_bank_q;
    logic rd_live_q;
    logic [CNT_W-1:0] rd_left_q;
    logic [CNT_W-1:0] xs_cnt_q;
    logic [CNT_W-1:0] pre_cnt_q [NUM_BANKS];
    logic [ADDR_W-1:0] row_q [NUM_BANKS];
    logic [COL_W-1:0] col_q;
    logic [3:0] refresh_cnt_q;
    power_state_t ps_q;

    always_ff @(posedge clk) begin
        clk_s_q <= {clk_s_q[0], mem_clk};
        cke_s_q <= {cke_s_q[0], cke};
        cs_s_q  <= {cs_s_q[0], cs_n};
        ras_s_q <= {ras_s_q[0], ras_n};
        cas_s_q <= {cas_s_q[0], cas_n};
        we_s_q  <= {we_s_q[0], we_n};
        ba_s1_q <= bank_sel;
        ba_s2_q <= ba_s1_q;
        a_s1_q  <= addr;
        a_s2_q  <= a_s1_q;
        clk_prev_q <= clk_s_q[1];
    end

    wire        edge_w   = clk_s_q[1] & ~clk_prev_q;
    wire [3:0]  cmd_w    = {cs_s_q[1], ras_s_q[1], cas_s_q[1], we_s_q[1]};
    wire        cke_w    = cke_s_q[1];
    wire [BANK_W-1:0] ba_w = ba_s2_q;
    wire        all_bit_w = a_s2_q[AP_BIT];
    wire        all_idle_w = &bank_idle_q;
    wire        any_open_w = |bank_open_q;
    // Commands take effect only with enable high at both edges
    wire        run_w    = edge_w & cke_w & cke_prev_q & (ps_q == PS_ACTIVE);
    wire        sel_w    = run_w & ~cmd_w[3];
    wire        is_nop_w = (cmd_w == CMD_NOP) | cmd_w[3];
    wire        is_act_w = sel_w & (cmd_w == CMD_ACT);
    wire        is_rd_w  = sel_w & (cmd_w == CMD_READ);
    wire        is_wr_w  = sel_w & (cmd_w == CMD_WRITE);
    wire        is_pre_w = sel_w & (cmd_w == CMD_PRE);
    wire        is_bst_w = sel_w & (cmd_w == CMD_BST) & rd_live_q
                           & (ba_w == rd_bank_q);
    wire        is_ref_w = sel_w & (cmd_w == CMD_REF) & all_idle_w;
    wire        is_mode_w = sel_w & (cmd_w == CMD_MODE) & all_idle_w;
    wire        sr_enter_w = edge_w & cke_prev_q & ~cke_w & (ps_q == PS_ACTIVE)
                           & ~cmd_w[3] & (cmd_w == CMD_REF) & all_idle_w;
    wire        pd_enter_w = edge_w & cke_prev_q & ~cke_w & (ps_q == PS_ACTIVE)
                           & is_nop_w;
    wire        exit_w   = edge_w & ~cke_prev_q & cke_w & is_nop_w
                           & (ps_q != PS_ACTIVE);
    wire        rd_ok_w  = bank_open_q[ba_w] & read_ready_q;
    wire        wr_ok_w  = bank_open_q[ba_w];
    wire        ap_w     = a_s2_q[AP_BIT];

    logic [2:0]       ev_kind;
    logic             ev_push;
    wire              fifo_ready;
    always_comb begin
        ev_kind = 3'h0;
        if (is_act_w) ev_kind = EV_ACT;
        else if (is_rd_w & rd_ok_w) ev_kind = EV_READ;
        else if (is_wr_w & wr_ok_w) ev_kind = EV_WRITE;
        else if (is_pre_w) ev_kind = EV_PRE;
        else if (is_bst_w) ev_kind = EV_BST;
        else if (is_ref_w) ev_kind = EV_REF;
        else if (is_mode_w) ev_kind = EV_MODE;
    end
    assign ev_push = (ev_kind != 3'h0);
    wire [WIDTH-1:0] ev_word = WIDTH'({ev_kind, ap_w, ba_w, a_s2_q});

    always_ff @(posedge clk) begin
        if (reset) begin
            cke_prev_q <= 1'b0;
            ps_q       <= PS_ACTIVE;
            xs_cnt_q   <= '0;
            read_ready_q <= 1'b1;
            cmd_lost_q <= 1'b0;
        end else begin
            if (edge_w) cke_prev_q <= cke_w;
            if (pd_enter_w & all_idle_w) ps_q <= PS_PRE_PDN;
            else if (pd_enter_w & any_open_w) ps_q <= PS_ACT_PDN;
            else if (pd_enter_w) ps_q <= PS_PRE_PDN;
            else if (sr_enter_w) ps_q <= PS_SELF_REF;
            else if (exit_w) ps_q <= PS_ACTIVE;
            if (sr_enter_w) read_ready_q <= 1'b0;
            if (exit_w & (ps_q == PS_SELF_REF)) xs_cnt_q <= CNT_W'(DLL_LOCK_CYC);
            else if (edge_w & (xs_cnt_q != '0) & cke_w) begin
                xs_cnt_q <= xs_cnt_q - 1'b1;
                if (xs_cnt_q == CNT_W'(1)) read_ready_q <= 1'b1;
            end
            if (ev_push & ~fifo_ready) cmd_lost_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= '0;
            rd_live_q <= 1'b0;
            rd_bank_q <= '0;
            rd_left_q <= '0;
            col_q <= '0;
            refresh_cnt_q <= '0;
        end else begin
            if (is_mode_w) mode_q <= a_s2_q;
            if (is_ref_w) refresh_cnt_q <= refresh_cnt_q + 1'b1;
            if ((is_rd_w & rd_ok_w) | (is_wr_w & wr_ok_w))
                col_q <= a_s2_q[COL_W-1:0];
            if (is_rd_w & rd_ok_w & ~ap_w) begin
                rd_live_q <= 1'b1;
                rd_bank_q <= ba_w;
                rd_left_q <= CNT_W'(BURST_CNT / 2);
            end else if (is_bst_w | (is_wr_w & wr_ok_w)) begin
                rd_live_q <= 1'b0;
            end else if (edge_w & rd_live_q) begin
                rd_left_q <= rd_left_q - 1'b1;
                if (rd_left_q == CNT_W'(1)) rd_live_q <= 1'b0;
            end
        end
    end

    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            wire this_w  = (ba_w == BANK_W'(b));
            wire close_w = is_pre_w & (all_bit_w | this_w);
            always_ff @(posedge clk) begin
                if (reset) begin
                    bank_open_q[b] <= 1'b0;
                    bank_idle_q[b] <= 1'b1;
                    pre_cnt_q[b]   <= '0;
                    row_q[b]       <= '0;
                end else if (is_act_w & this_w & bank_idle_q[b]) begin
                    bank_open_q[b] <= 1'b1;
                    bank_idle_q[b] <= 1'b0;
                    row_q[b]       <= a_s2_q;
                end else if (close_w & bank_open_q[b]) begin
                    bank_open_q[b] <= 1'b0;
                    pre_cnt_q[b]   <= CNT_W'(PRECHARGE_CYC);
                end else if (~bank_open_q[b] & ~bank_idle_q[b] & edge_w) begin
                    if (pre_cnt_q[b] <= CNT_W'(1)) bank_idle_q[b] <= 1'b1;
                    pre_cnt_q[b] <= pre_cnt_q[b] - 1'b1;
                end
            end
        end
    endgenerate

    assign power_state_q = ps_q;

    ddr_event_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (ev_push),
        .in_ready  (fifo_ready),
        .in_data   (ev_word),
        .out_valid (ev_valid),
        .out_ready (ev_ready),
        .out_data  (ev_data)
    );

    chk_bank_idle_wait: assert property (@(posedge clk) disable iff (reset)
        $rose(bank_idle_q[0]) |-> $past(bank_open_q[0], 1) == 1'b0)
        else $error("bank went idle while open");
    chk_sr_entry: assert property (@(posedge clk) disable iff (reset)
        sr_enter_w |=> (ps_q == PS_SELF_REF) & ~read_ready_q)
        else $error("self refresh not entered");
    chk_pd_kind: assert property (@(posedge clk) disable iff (reset)
        pd_enter_w & any_open_w |=> ps_q == PS_ACT_PDN)
        else $error("wrong power-down kind");
    chk_hold_low: assert property (@(posedge clk) disable iff (reset)
        edge_w & ~cke_w & ~cke_prev_q & (ps_q != PS_ACTIVE) |=> $stable(ps_q))
        else $error("power state left with enable low");
    chk_deselect_quiet: assert property (@(posedge clk) disable iff (reset)
        cmd_w[3] |-> ~ev_push)
        else $error("command registered while deselected");
    chk_mode_idle: assert property (@(posedge clk) disable iff (reset)
        run_w & (cmd_w == CMD_MODE) |=>
            mode_q == ($past(all_idle_w) ? $past(a_s2_q) : $past(mode_q)))
        else $error("mode load wrong");
    chk_act_opens: assert property (@(posedge clk) disable iff (reset)
        is_act_w & bank_idle_q[ba_w] |=>
            bank_open_q[$past(ba_w)] & (row_q[$past(ba_w)] == $past(a_s2_q)))
        else $error("activate did not open bank");
    chk_bst_ends: assert property (@(posedge clk) disable iff (reset)
        is_bst_w |=> ~rd_live_q)
        else $error("burst stop ignored");
    chk_col_taken: assert property (@(posedge clk) disable iff (reset)
        (is_rd_w & rd_ok_w) | (is_wr_w & wr_ok_w) |=> col_q == $past(a_s2_q[COL_W-1:0]))
        else $error("column not taken");
    chk_one_refresh: assert property (@(posedge clk) disable iff (reset)
        is_ref_w |=> refresh_cnt_q == $past(refresh_cnt_q) + 4'h1)
        else $error("refresh count wrong");
    chk_lock_wait: assert property (@(posedge clk) disable iff (reset)
        exit_w & (ps_q == PS_SELF_REF) |=>
            ~read_ready_q & (xs_cnt_q == CNT_W'(DLL_LOCK_CYC)))
        else $error("lock wait not started");
endmodule // ddr_cmd_logic

module ddr_event_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, rp_q;
    logic [AW:0]      cnt_q;
    wire push_w = in_valid & in_ready;
    wire pop_w  = out_valid & out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
    always_ff @(posedge clk) begin
        if (reset) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push_w) wp_q <= wp_q + 1'b1;
            if (pop_w) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
        end
    end
    always_ff @(posedge clk) begin
        if (push_w) mem_q[wp_q] <= in_data;
    end
endmodule // ddr_event_fifo

// [rtl/ddr_cmd_pkg.sv]
// Constants for the DDR command and power-state logic.
// Assumes a single 100 MHz clock domain in the host design.
package ddr_cmd_pkg;
    localparam int CLK_MHZ    = 100;
    localparam int NUM_BANKS  = 4;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 14;
    localparam int COL_W      = 10;
    localparam int AP_BIT     = 10;
    localparam int BURST_CNT  = 8;
    localparam int READ_LAT   = 3;
    localparam int CNT_W      = 16;
    // Times in ns, counts derived by rounding a least time up
    localparam int PRECHARGE_PERIOD_NS = 20;
    localparam int PRECHARGE_CYC = (PRECHARGE_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int SR_EXIT_NS  = 200;
    localparam int SR_EXIT_CYC = (SR_EXIT_NS * CLK_MHZ + 999) / 1000;
    localparam int DLL_LOCK_CYC = 200;
    // Command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP   = 4'hF ^ 4'h8;
    localparam logic [3:0] CMD_MODE  = 4'h0;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_BST   = 4'h6;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [2:0] EV_ACT    = 3'h1;
    localparam logic [2:0] EV_READ   = 3'h2;
    localparam logic [2:0] EV_WRITE  = 3'h3;
    localparam logic [2:0] EV_PRE    = 3'h4;
    localparam logic [2:0] EV_BST    = 3'h5;
    localparam logic [2:0] EV_REF    = 3'h6;
    localparam logic [2:0] EV_MODE   = 3'h7;
    typedef enum logic [3:0] {
        PS_ACTIVE    = 4'h1,
        PS_PRE_PDN   = 4'h2,
        PS_ACT_PDN   = 4'h4,
        PS_SELF_REF  = 4'h8
    } power_state_t;
endpackage

// [tb/ddr_ctrl_model.sv]
// Memory controller model driving the command, bank, address and enable pins.
// Assumes the bench calls issue for one command per memory clock edge.
`timescale 1ns/10ps
module ddr_ctrl_model
    import ddr_cmd_pkg::*;
(
    // Bench clock
    input  wire logic                    clk,
    // Memory pins
    output logic                         mem_clk,
    output logic                         cke,
    output logic                         cs_n,
    output logic                         ras_n,
    output logic                         cas_n,
    output logic                         we_n,
    output logic [ddr_cmd_pkg::BANK_W-1:0] bank_sel,
    output logic [ddr_cmd_pkg::ADDR_W-1:0] addr
);
    initial begin
        {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
        cke      = 1'b0;
        bank_sel = 2'h0;
        addr     = 14'h0000;
        mem_clk  = 1'b0;
        #3;
        forever #40 mem_clk = ~mem_clk;
    end

    // One command per edge, then no-operation with the lines toggled
    task automatic issue(input logic [3:0] code, input logic [1:0] b,
                         input logic [13:0] a, input logic ce);
        @(negedge mem_clk);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = code;
        bank_sel = b;
        addr     = a;
        cke      = ce;
        @(posedge mem_clk);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
        bank_sel = ~bank_sel;
        addr     = ~addr;
    endtask

    task automatic nops(input int n, input logic ce);
        repeat (n) issue(CMD_NOP, ~bank_sel, ~addr, ce);
    endtask
endmodule // ddr_ctrl_model

// [tb/ddr_command_and_power_state_logic_tb.sv]
// Self-checking bench for the command decoder and power-state tracker.
// Assumes the controller model in ddr_ctrl_model and the event packing of the design.
`timescale 1ns/10ps
module ddr_command_and_power_state_logic_tb;
    import ddr_cmd_pkg::*;
    logic        clk, reset, ev_ready, stall, loose, mem_clk, cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0]  bank_sel;
    logic [13:0] addr;
    logic        ev_valid, read_ready_q, cmd_lost_q;
    logic [23:0] ev_data;
    logic [3:0]  bank_open_q, bank_idle_q, power_state_q;
    logic [31:0] seed = 32'h32A4903C;
    logic [13:0] a;
    logic [23:0] exp_q[$];
    int          err_total = 0;
    int          n_compared = 0;

    ddr_ctrl_model u_ddr_ctrl_model (.clk(clk), .mem_clk(mem_clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel), .addr(addr));
    ddr_cmd_logic #(.WIDTH(24), .DEPTH(16)) u_ddr_cmd_logic (.clk(clk), .reset(reset),
        .mem_clk(mem_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_sel(bank_sel), .addr(addr), .ev_valid(ev_valid), .ev_ready(ev_ready),
        .ev_data(ev_data), .bank_open_q(bank_open_q), .bank_idle_q(bank_idle_q),
        .power_state_q(power_state_q), .read_ready_q(read_ready_q), .cmd_lost_q(cmd_lost_q));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [23:0] ev_word(logic [2:0] k, logic [1:0] b, logic [13:0] ad);
        return {4'h0, k, ad[AP_BIT], b, ad};
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic settle();
        repeat (6) @(negedge clk);
    endtask

    task automatic cmd(input logic [3:0] code, input logic [2:0] k, input logic [1:0] b,
                       input logic [13:0] ad, input bit take, input logic ce = 1'b1);
        u_ddr_ctrl_model.issue(code, b, ad, ce);
        if (take) exp_q.push_back(ev_word(k, b, ad));
        settle();
    endtask

    task automatic drain();
        int i;
        for (i = 0; i < 3000 && (exp_q.size() != 0 || ev_valid); i++) @(negedge clk);
        check(24'(exp_q.size()), 24'h0, "events left");
    endtask

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Random stalls on the drain side
    always @(negedge clk) ev_ready <= stall ? 1'b0 : rnd() & 1;

    always @(posedge clk) begin
        if (!reset && ev_valid && ev_ready && !loose) begin
            if (exp_q.size() == 0) check(ev_data, 24'hFFFFFF, "spare event");
            else check(ev_data, exp_q.pop_front(), "event");
        end
    end

    initial begin
        #300000;
        err_total++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        stall = 1'b0;
        loose = 1'b0;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        u_ddr_ctrl_model.nops(2, 1'b1);
        for (int b = 0; b < 4; b++) cmd(CMD_ACT, EV_ACT, 2'(b), 14'(rnd()), 1);
        check(24'(bank_open_q), 24'hF, "banks open");
        a = 14'(rnd()) & 14'h03FF;
        cmd(CMD_READ, EV_READ, 2'h0, a, 1);
        cmd(CMD_BST, EV_BST, 2'h1, 14'(rnd()), 0);
        cmd(CMD_BST, EV_BST, 2'h0, 14'(rnd()), 1);
        check(24'(bank_open_q), 24'hF, "open after stop");
        cmd(CMD_WRITE, EV_WRITE, 2'h1, 14'(rnd()) & 14'h03FF, 1);
        cmd(CMD_BST, EV_BST, 2'h0, 14'(rnd()), 0);
        cmd(CMD_REF, EV_REF, 2'h0, 14'h0000, 0);
        cmd(CMD_MODE, EV_MODE, 2'h0, 14'(rnd()), 0);
        cmd({1'b1, 3'(rnd())}, EV_ACT, 2'h3, 14'(rnd()), 0);
        cmd(CMD_NOP, EV_ACT, 2'h3, 14'(rnd()), 0);
        cmd(CMD_PRE, EV_PRE, 2'h2, 14'(rnd()) & 14'h3BFF, 1);
        check(24'(bank_open_q), 24'hB, "one bank closed");
        cmd(CMD_READ, EV_READ, 2'h2, 14'h0010, 0);
        cmd(CMD_NOP, EV_ACT, 2'h0, 14'h0000, 0, 1'b0);
        check(24'(power_state_q), 24'(PS_ACT_PDN), "active pdn");
        u_ddr_ctrl_model.nops(3, 1'b0);
        check(24'(power_state_q), 24'(PS_ACT_PDN), "pdn held");
        cmd(CMD_NOP, EV_ACT, 2'h0, 14'h0000, 0);
        check(24'(power_state_q), 24'(PS_ACTIVE), "pdn exit");
        cmd(CMD_PRE, EV_PRE, 2'(rnd()), 14'h0400, 1);
        check(24'(bank_open_q), 24'h0, "all closed");
        check(24'(bank_idle_q), 24'h4, "not idle yet");
        u_ddr_ctrl_model.nops(3, 1'b1);
        check(24'(bank_idle_q), 24'hF, "idle");
        cmd(CMD_NOP, EV_ACT, 2'h0, 14'h0000, 0, 1'b0);
        check(24'(power_state_q), 24'(PS_PRE_PDN), "precharge pdn");
        cmd(CMD_NOP, EV_ACT, 2'h0, 14'h0000, 0);
        u_ddr_ctrl_model.nops(1, 1'b1);
        cmd(CMD_MODE, EV_MODE, 2'h0, 14'(rnd()), 1);
        u_ddr_ctrl_model.nops(2, 1'b1);
        repeat (2) cmd(CMD_REF, EV_REF, 2'h0, 14'h0000, 1);
        drain();
        loose = 1'b1;
        cmd(CMD_REF, EV_REF, 2'h0, 14'h0000, 0, 1'b0);
        check(24'(power_state_q), 24'(PS_SELF_REF), "self refresh");
        u_ddr_ctrl_model.nops(2, 1'b0);
        check(24'({power_state_q, read_ready_q}), 24'({PS_SELF_REF, 1'b0}), "sr held");
        cmd(CMD_NOP, EV_ACT, 2'h0, 14'h0000, 0);
        check(24'(power_state_q), 24'(PS_ACTIVE), "sr exit");
        loose = 1'b0;
        u_ddr_ctrl_model.nops(185, 1'b1);
        check(24'(read_ready_q), 24'h0, "lock wait");
        u_ddr_ctrl_model.nops(20, 1'b1);
        check(24'(read_ready_q), 24'h1, "lock done");
        stall = 1'b1;
        for (int i = 0; i < 18; i++) cmd(CMD_REF, EV_REF, 2'h0, 14'h0000, i < 16);
        check(24'(cmd_lost_q), 24'h1, "overflow");
        stall = 1'b0;
        drain();
        close_out();
    end
endmodule // ddr_command_and_power_state_logic_tb
